// File: core/ppn_consts.vh
// Command codes, reset values, field layouts and copy engine geometry of the command-register block.
`ifndef PPN_CONSTS_VH
`define PPN_CONSTS_VH

// Command codes on the management bus.
`define PPN_CMD_OPERATION      8'h01
`define PPN_CMD_ON_OFF_CONFIG  8'h02
`define PPN_CMD_PHASE_SELECT   8'h04
`define PPN_CMD_WRITE_GUARD    8'h10
`define PPN_CMD_SAVE_TO_NVM    8'h15
`define PPN_CMD_LOAD_FROM_NVM  8'h16
`define PPN_CMD_FEATURE_SUMM   8'h19
`define PPN_CMD_VOUT_COMMAND   8'h21

// Phase selection values.
`define PPN_PHASE_RESET        8'hff
`define PPN_PHASE_MAX          8'h03

// Write guard encodings.
`define PPN_WG_OPEN            8'h00
`define PPN_WG_OP_CFG_VOUT     8'h20
`define PPN_WG_OP_ONLY         8'h40
`define PPN_WG_LOCKED          8'h80
`define PPN_WG_RESET           8'h00

// Feature summary fields.
`define PPN_FS_PEC             1'b1
`define PPN_FS_SPEED           2'b10
`define PPN_FS_ALERT           1'b1
`define PPN_FS_FORMAT          1'b0
`define PPN_FS_AVSBUS          1'b0

// Copy engine geometry.
`define PPN_MEM_AW             6
`define PPN_MEM_LAST           6'h3f
`define PPN_NUM_STRAP          4

`endif

// File: core/ppn_guard_check.v
// Write guard decode: whether a command may be written under the present guard value.
`timescale 1ns/1ns
`include "ppn_consts.vh"

module ppn_guard_check (
  // Guard setting and addressed command.
  input  wire [7:0] guard_val,
  input  wire [7:0] cmd_code,
  // Decision.
  output reg        write_ok,
  output wire       guard_val_valid
);

  // Only the four listed encodings are legal guard values.
  assign guard_val_valid = (guard_val == `PPN_WG_OPEN) || (guard_val == `PPN_WG_OP_CFG_VOUT) ||
                           (guard_val == `PPN_WG_OP_ONLY) || (guard_val == `PPN_WG_LOCKED);

  // Allowed-command set shrinks as the guard value rises.
  always @* begin
    write_ok = 1'b0;
    case (guard_val)
      `PPN_WG_OPEN: write_ok = 1'b1; // [R5]
      `PPN_WG_OP_CFG_VOUT: write_ok = (cmd_code == `PPN_CMD_WRITE_GUARD) ||
                                    (cmd_code == `PPN_CMD_OPERATION) ||
                                    (cmd_code == `PPN_CMD_ON_OFF_CONFIG) ||
                                    (cmd_code == `PPN_CMD_SAVE_TO_NVM) ||
                                    (cmd_code == `PPN_CMD_VOUT_COMMAND); // [R6]
      `PPN_WG_OP_ONLY: write_ok = (cmd_code == `PPN_CMD_WRITE_GUARD) ||
                                (cmd_code == `PPN_CMD_OPERATION) ||
                                (cmd_code == `PPN_CMD_SAVE_TO_NVM); // [R7]
      `PPN_WG_LOCKED: write_ok = (cmd_code == `PPN_CMD_WRITE_GUARD) ||
                               (cmd_code == `PPN_CMD_SAVE_TO_NVM); // [R8]
      default: write_ok = 1'b0;
    endcase
  end

endmodule

// File: core/ppn_copy_engine.v
// Sequencer that walks memory locations for save, restore and strap override.
`timescale 1ns/1ns
`include "ppn_consts.vh"

module ppn_copy_engine (
  // Clock and reset.
  input  wire                   core_clk,
  input  wire                   nrst,
  // Start strobes.
  input  wire                   start_save,
  input  wire                   start_load,
  // Location map and override selection.
  input  wire                   loc_in_user,
  input  wire                   loc_in_oper,
  input  wire [`PPN_NUM_STRAP-1:0] strap_value_override_select,
  // Walk outputs.
  output reg  [`PPN_MEM_AW-1:0] addr_q,
  output reg                    save_we_q,
  output reg                    load_we_q,
  output reg                    strap_we_q,
  output reg  [1:0]             strap_idx_q,
  output reg                    reg_off_q,
  output wire                   busy
);

  localparam S_IDLE  = 4'b0001;
  localparam S_SAVE  = 4'b0010;
  localparam S_LOAD  = 4'b0100;
  localparam S_STRAP = 4'b1000;

  reg [3:0] state_q;

  assign busy = (state_q != S_IDLE);

  // Walk every location; one write strobe per mapped location.
  always @(posedge core_clk) begin
    if (!nrst) begin
      state_q     <= S_IDLE;
      addr_q      <= {`PPN_MEM_AW{1'b0}};
      save_we_q   <= 1'b0;
      load_we_q   <= 1'b0;
      strap_we_q  <= 1'b0;
      strap_idx_q <= 2'b00;
      reg_off_q   <= 1'b0;
    end else begin
      save_we_q  <= 1'b0;
      load_we_q  <= 1'b0;
      strap_we_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          addr_q      <= {`PPN_MEM_AW{1'b0}};
          strap_idx_q <= 2'b00;
          // Regulation is dropped only when a restore starts.
          reg_off_q   <= !start_save && start_load; // [R16]
          if (start_save) begin
            state_q <= S_SAVE; // [R11]
          end else if (start_load) begin
            state_q <= S_LOAD;
          end
        end
        S_SAVE: begin
          save_we_q <= loc_in_oper && loc_in_user; // [R12]
          addr_q    <= addr_q + 1'b1;
          if (addr_q == `PPN_MEM_LAST) begin
            state_q <= S_IDLE;
          end
        end
        S_LOAD: begin
          load_we_q <= loc_in_oper && loc_in_user; // [R18]
          addr_q    <= addr_q + 1'b1;
          if (addr_q == `PPN_MEM_LAST) begin
            state_q <= S_STRAP;
          end
        end
        S_STRAP: begin
          strap_we_q  <= strap_value_override_select[strap_idx_q]; // [R17]
          strap_idx_q <= strap_idx_q + 1'b1;
          // Regulation stays off while the last override strobe still stands.
          if (strap_idx_q == 2'b11) begin
            state_q <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

endmodule

// File: core/ppn_cmd_regs.v
// Command-register bank: phase select, write guard, NVM save/restore and feature summary.
`timescale 1ns/1ns
`include "ppn_consts.vh"

//Contract
// [R1] Phase values 00h-03h pick phases one-four.
// [R2] Phase 04h-FEh or unsupported: invalid, flagged.
// [R3] Phase resets FFh meaning all phases.
// [R4] Latest phase selection persists for later commands.
// [R5] Guard 00h allows every write.
// [R6] Guard 20h: guard, operation, config, save, vout.
// [R7] Guard 40h: guard, operation, save only.
// [R8] Guard 80h: guard and save only.
// [R9] Other guard values: invalid, flagged.
// [R10] Reads always return parameters regardless of guard; reads arriving while a copy walk runs are dropped unanswered.
// [R11] Save command copies operating memory to NVM.
// [R12] Save skips locations without user-store match.
// [R13] Save not blocked while regulating; commands dropped.
// [R14] Host stops regulation, waits 100 ms.
// [R15] Host saves only with phase FFh.
// [R16] Restore disables operation, loads user store.
// [R17] Restore then applies strap overrides selected.
// [R18] Restore skips locations without operating match.
// [R19] Host restores only with phase FFh.
// [R20] Feature summary byte is read-only, fixed.
// [R21] Rejected writes leave register unchanged.
module ppn_cmd_regs (
  // Clock and reset.
  input  wire                      core_clk,
  input  wire                      nrst,
  // Command port from the bus protocol engine.
  input  wire                      cmd_wr,
  input  wire                      cmd_rd,
  input  wire [7:0]                cmd_code,
  input  wire [7:0]                cmd_wdata,
  output reg  [7:0]                cmd_rdata_q,
  output reg                       cmd_rvalid_q,
  output reg                       cmd_invalid_q,
  output reg                       cmd_denied_q,
  output wire                      cmd_busy,
  // Phase configuration.
  input  wire [2:0]                phase_count,
  output wire [7:0]                phase_sel,
  output wire                      phase_all,
  // Memory location map and strap inputs.
  input  wire                      loc_in_user,
  input  wire                      loc_in_oper,
  input  wire [`PPN_NUM_STRAP-1:0] strap_value_override_select,
  // Copy strobes toward operating memory and NVM.
  output wire [`PPN_MEM_AW-1:0]    mem_addr,
  output wire                      nvm_save_we,
  output wire                      oper_load_we,
  output wire                      oper_strap_we,
  output wire [1:0]                strap_idx,
  output wire                      regulation_off
);

  reg  [7:0] phase_q;
  reg  [7:0] guard_q;
  wire       write_ok;
  wire       guard_ok;
  wire       phase_ok;
  wire       start_save;
  wire       start_load;
  wire       eng_busy;
  wire [7:0] guard_cand;

  // Phase value is supported when at most 03h and below the configured phase count, or FFh.
  function phase_valid;
    input [7:0] val;
    input [2:0] count;
    begin
      phase_valid = (val == `PPN_PHASE_RESET) ||
                    ((val <= `PPN_PHASE_MAX) && (val < {5'b0_0000, count}));
    end
  endfunction

  assign phase_ok   = phase_valid(cmd_wdata, phase_count); // [R2]
  assign phase_sel  = phase_q; // [R1]
  assign phase_all  = (phase_q == `PPN_PHASE_RESET); // [R3]
  assign guard_cand = (cmd_code == `PPN_CMD_WRITE_GUARD) ? cmd_wdata : guard_q;
  assign cmd_busy   = eng_busy;

  // Guard decode for the present command.
  ppn_guard_check u_guard (
    .guard_val       (guard_q),
    .cmd_code        (cmd_code),
    .write_ok        (write_ok),
    .guard_val_valid ()
  );

  // Legality of a new guard value being written.
  ppn_guard_check u_guard_new (
    .guard_val       (guard_cand),
    .cmd_code        (cmd_code),
    .write_ok        (),
    .guard_val_valid (guard_ok)
  );

  // Commands arriving while a copy runs are dropped.
  assign start_save = cmd_wr && !eng_busy && write_ok &&
                      (cmd_code == `PPN_CMD_SAVE_TO_NVM); // [R13]
  assign start_load = cmd_wr && !eng_busy && write_ok &&
                      (cmd_code == `PPN_CMD_LOAD_FROM_NVM);

  ppn_copy_engine u_copy (
    .core_clk                    (core_clk),
    .nrst                        (nrst),
    .start_save                  (start_save),
    .start_load                  (start_load),
    .loc_in_user                 (loc_in_user),
    .loc_in_oper                 (loc_in_oper),
    .strap_value_override_select (strap_value_override_select),
    .addr_q                      (mem_addr),
    .save_we_q                   (nvm_save_we),
    .load_we_q                   (oper_load_we),
    .strap_we_q                  (oper_strap_we),
    .strap_idx_q                 (strap_idx),
    .reg_off_q                   (regulation_off),
    .busy                        (eng_busy)
  );

  // Register writes with guard and value checks; rejected writes keep state.
  always @(posedge core_clk) begin
    if (!nrst) begin
      phase_q       <= `PPN_PHASE_RESET; // [R3]
      guard_q       <= `PPN_WG_RESET;
      cmd_invalid_q <= 1'b0;
      cmd_denied_q  <= 1'b0;
    end else begin
      cmd_invalid_q <= 1'b0;
      cmd_denied_q  <= 1'b0;
      if (cmd_wr && !eng_busy) begin
        if (!write_ok) begin
          cmd_denied_q <= 1'b1; // [R21]
        end else begin
          case (cmd_code)
            `PPN_CMD_PHASE_SELECT: begin
              if (phase_ok) begin
                phase_q <= cmd_wdata; // [R4]
              end else begin
                cmd_invalid_q <= 1'b1; // [R2] [R21]
              end
            end
            `PPN_CMD_WRITE_GUARD: begin
              if (guard_ok) begin
                guard_q <= cmd_wdata;
              end else begin
                cmd_invalid_q <= 1'b1; // [R9] [R21]
              end
            end
            `PPN_CMD_FEATURE_SUMM: cmd_invalid_q <= 1'b1; // [R20]
            default: cmd_invalid_q <= 1'b0;
          endcase
        end
      end
    end
  end

  // Reads answer one cycle later, ignoring the guard.
  always @(posedge core_clk) begin
    if (!nrst) begin
      cmd_rdata_q  <= 8'h00;
      cmd_rvalid_q <= 1'b0;
    end else begin
      cmd_rvalid_q <= cmd_rd && !eng_busy; // [R10]
      if (cmd_rd && !eng_busy) begin
        case (cmd_code)
          `PPN_CMD_PHASE_SELECT: cmd_rdata_q <= phase_q;
          `PPN_CMD_WRITE_GUARD:  cmd_rdata_q <= guard_q;
          `PPN_CMD_FEATURE_SUMM: cmd_rdata_q <= {`PPN_FS_PEC, `PPN_FS_SPEED, `PPN_FS_ALERT,
                                                 `PPN_FS_FORMAT, `PPN_FS_AVSBUS,
                                                 2'b00}; // [R20]
          default:               cmd_rdata_q <= 8'h00;
        endcase
      end
    end
  end

endmodule

// File: verification/ppn_mem_map_model.sv
// Location map of operating memory and user store seen by the copy walk.
`timescale 1ns/1ns
module ppn_mem_map_model (
  // Walk address from the block.
  input  logic [5:0] mem_addr,
  // Presence of the location in each memory.
  output logic       loc_in_user,
  output logic       loc_in_oper
);
  // Sparse maps, so that both kinds of skip occur in every walk.
  assign loc_in_user = mem_addr[0] | mem_addr[3];
  assign loc_in_oper = ~mem_addr[1];
endmodule

// File: verification/ppn_cmd_regs_asserts.sv
// Port-level assertions of the command-register block.
`timescale 1ns/1ns
module ppn_cmd_regs_asserts (
  // Clock, reset and command port.
  input logic       core_clk,
  input logic       nrst,
  input logic       cmd_wr,
  input logic       cmd_rd,
  input logic [7:0] cmd_code,
  input logic [7:0] cmd_wdata,
  input logic [7:0] cmd_rdata_q,
  input logic       cmd_rvalid_q,
  input logic       cmd_invalid_q,
  input logic       cmd_denied_q,
  input logic       cmd_busy,
  // Phase and copy walk.
  input logic [7:0] phase_sel,
  input logic       loc_in_user,
  input logic       loc_in_oper,
  input logic [3:0] strap_value_override_select,
  input logic       nvm_save_we,
  input logic       oper_load_we,
  input logic       oper_strap_we,
  input logic [1:0] strap_idx,
  input logic       regulation_off
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // A write seen while idle is taken; both marks a location present in both memories.
  wire wr_ok = cmd_wr && !cmd_busy;
  wire both  = loc_in_user && loc_in_oper;
  // Selection bit of the strap index presented before the strobe; the index has moved on since.
  wire strap_sel = strap_value_override_select[strap_idx];
  property p_rst; disable iff (1'b0) !nrst |=> phase_sel == 8'hff; endproperty
  property p_rng; phase_sel <= 8'h03 || phase_sel == 8'hff; endproperty
  property p_bad; wr_ok && cmd_code == 8'h04 && cmd_wdata inside {[8'h04:8'hfe]}
    |=> (cmd_invalid_q || cmd_denied_q) && $stable(phase_sel); endproperty
  property p_feat; cmd_rd && !cmd_busy && cmd_code == 8'h19
    |=> cmd_rvalid_q && cmd_rdata_q == 8'hd0; endproperty
  property p_drop; cmd_busy && (cmd_wr || cmd_rd)
    |=> !cmd_rvalid_q && !cmd_invalid_q && !cmd_denied_q; endproperty
  property p_save; wr_ok && cmd_code == 8'h15 |=> cmd_busy [*8]; endproperty
  property p_smap; nvm_save_we |-> $past(both) && !regulation_off; endproperty
  property p_lmap; oper_load_we |-> $past(both) && regulation_off; endproperty
  property p_strap; oper_strap_we |-> regulation_off && $past(strap_sel); endproperty
  a_rst: assert property (p_rst) else $error("phase not reset");
  a_rng: assert property (p_rng) else $error("phase out of range");
  a_bad: assert property (p_bad) else $error("bad phase taken");
  a_feat: assert property (p_feat) else $error("feature byte wrong");
  a_drop: assert property (p_drop) else $error("request answered while busy");
  a_save: assert property (p_save) else $error("save walk missing");
  a_smap: assert property (p_smap) else $error("bad save strobe");
  a_lmap: assert property (p_lmap) else $error("bad load strobe");
  a_strap: assert property (p_strap) else $error("bad strap strobe");
  c_save: cover property (nvm_save_we);
  c_strap: cover property (oper_strap_we);
  c_deny: cover property (cmd_denied_q);
endmodule

bind ppn_cmd_regs ppn_cmd_regs_asserts ppn_cmd_regs_asserts_i (.core_clk, .nrst, .cmd_wr,
  .cmd_rd, .cmd_code, .cmd_wdata, .cmd_rdata_q, .cmd_rvalid_q, .cmd_invalid_q, .cmd_denied_q,
  .cmd_busy, .phase_sel, .loc_in_user, .loc_in_oper, .strap_value_override_select,
  .nvm_save_we, .oper_load_we, .oper_strap_we, .strap_idx, .regulation_off);

// File: verification/ppn_cmd_regs_tb_top.sv
// Self-checking bench of the command-register block.
`timescale 1ns/1ns
module ppn_cmd_regs_tb_top;
  logic        core_clk = 0, nrst = 0, cmd_wr = 0, cmd_rd = 0;
  logic        loc_in_user, loc_in_oper, cmd_rvalid_q, cmd_invalid_q, cmd_denied_q, sel_prev;
  logic        cmd_busy, phase_all, nvm_save_we, oper_load_we, oper_strap_we, regulation_off;
  logic [7:0]  cmd_code = 8'h00, cmd_wdata = 8'h00, cmd_rdata_q, phase_sel, g, v, ph, c;
  logic [5:0]  mem_addr;
  logic [3:0]  strap_value_override_select = 4'h0;
  logic [2:0]  phase_count = 3'h4;
  logic [1:0]  strap_idx;
  logic [31:0] seed = 32'h0000_0c6a;
  int          n_fail, n_compared, n_sv, n_ld, n_st, n_bad;

  ppn_cmd_regs ppn_cmd_regs_i (.core_clk, .nrst, .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata,
    .cmd_rdata_q, .cmd_rvalid_q, .cmd_invalid_q, .cmd_denied_q, .cmd_busy, .phase_count,
    .phase_sel, .phase_all, .loc_in_user, .loc_in_oper, .strap_value_override_select,
    .mem_addr, .nvm_save_we, .oper_load_we, .oper_strap_we, .strap_idx, .regulation_off);
  ppn_mem_map_model ppn_mem_map_model_i (.mem_addr, .loc_in_user, .loc_in_oper);

  // Core clock at 100 MHz.
  initial forever #5 core_clk = ~core_clk;

  // Tallies copy strobes; a load after a strap, or an unselected strap, is out of order.
  always @(posedge core_clk) begin
    n_sv += nvm_save_we;
    n_ld += oper_load_we;
    n_st += oper_strap_we;
    n_bad += oper_load_we && n_st > 0 || oper_strap_we && !sel_prev;
    sel_prev = strap_value_override_select[strap_idx];
  end

  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Whether the present guard value g lets a write to command a through.
  function logic ok(input logic [7:0] a);
    return g == 8'h00 || a inside {8'h10, 8'h15} || g != 8'h80 && a == 8'h01
      || g == 8'h20 && a inside {8'h02, 8'h21};
  endfunction
  // Locations present in both maps of the model.
  function int n_both();
    n_both = 0;
    for (int a = 0; a < 64; a++)
      n_both += ((a & 9) != 0 && (a & 2) == 0);
  endfunction

  task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One request held from just after an edge to the next; the answer is visible on return.
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) #1;
    cmd_wr = w;
    cmd_rd = !w;
    cmd_code = a;
    cmd_wdata = d;
    @(posedge core_clk) #1;
    cmd_wr = 0;
    cmd_rd = 0;
  endtask
  task rd(input string nm, input logic [7:0] a, input logic [7:0] e);
    xfer(0, a, 8'h00);
    chk(nm, e, cmd_rdata_q);
  endtask
  // Waits, bounded, for the copy walk to finish.
  task settle();
    for (int t = 0; t < 300 && cmd_busy; t++)
      @(posedge core_clk) #1;
    repeat (2) @(posedge core_clk) #1;
    chk("idle", 8'h00, {7'h00, cmd_busy});
    chk("walk_end", 8'h00, {2'b00, mem_addr});
  endtask
  task complete_run();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    #30000;
    n_fail++;
    complete_run();
  end

  // Main sequence.
  initial begin
    repeat (5) @(posedge core_clk);
    #1 nrst = 1;
    chk("phase_rst", 8'hff, phase_sel);
    for (int n = 1; n <= 4; n++) begin
      phase_count = 3'(n);
      for (int p = 0; p < 6; p++) begin
        seed = lfsr(seed);
        v = p < 4 ? 8'(p) : p == 4 ? 8'h04 + seed[7:0] % 8'hfb : 8'hfe;
        ph = phase_sel;
        xfer(1, 8'h04, v);
        chk("phase_inv", {7'h00, p >= n}, {7'h00, cmd_invalid_q});
        chk("phase", p < n ? v : ph, phase_sel);
      end
    end
    chk("phase_all", 8'h00, {7'h00, phase_all});
    for (int i = 0; i < 4; i++) begin
      g = i == 0 ? 8'h00 : 8'h10 << i;
      xfer(1, 8'h10, g);
      for (int j = 0; j < 4; j++) begin
        c = j == 3 ? 8'h21 : 8'h01 << j;
        ph = phase_sel;
        xfer(1, c, ph ^ 8'h01);
        chk("denied", {7'h00, !ok(c)}, {7'h00, cmd_denied_q});
        chk("phase_wg", c == 8'h04 && ok(c) ? ph ^ 8'h01 : ph, phase_sel);
      end
      rd("guard_rd", 8'h10, g);
      rd("feat_rd", 8'h19, 8'hd0);
    end
    seed = lfsr(seed);
    xfer(1, 8'h10, seed[7:0] | 8'h01);
    chk("guard_inv", 8'h01, {7'h00, cmd_invalid_q});
    rd("guard_keep", 8'h10, 8'h80);
    xfer(1, 8'h10, 8'h00);
    xfer(1, 8'h19, 8'h5a);
    chk("feat_wr", 8'h01, {7'h00, cmd_invalid_q});
    xfer(1, 8'h04, 8'hff);
    chk("phase_all", 8'h01, {7'h00, phase_all});
    xfer(1, 8'h15, 8'h00);
    chk("save_busy", 8'h01, {7'h00, cmd_busy});
    xfer(0, 8'h19, 8'h00);
    chk("drop", 8'h00, {7'h00, cmd_rvalid_q});
    settle();
    chk("save_cnt", 8'(n_both()), 8'(n_sv));
    strap_value_override_select = seed[11:8] | 4'h1;
    xfer(1, 8'h16, 8'h00);
    chk("reg_off", 8'h01, {7'h00, regulation_off});
    settle();
    chk("reg_on", 8'h00, {7'h00, regulation_off});
    chk("load_cnt", 8'(n_both()), 8'(n_ld));
    chk("strap_cnt", 8'($countones(strap_value_override_select)), 8'(n_st));
    chk("order", 8'h00, 8'(n_bad));
    complete_run();
  end
endmodule
